// ### core/sram_core_cfg.svh
// Function
// - Byte write selects sampled on positive and again on negative input clock rise.
// - A write lane is stored only when its select is low; lanes 0 and 1.
// - First write word and its selects are taken on positive input clock rise.
// - Second write word and its selects are taken on next negative clock rise.
// - Read right after write to same address returns the just-written data.
// - Burst-start word bit 0 gives order 0,1; value 1 gives order 1,0.
// - Output loop needs 1024 input clock cycles to lock after clocks settle.
// - Positive input clock static for 30 ns resets the loop, relock needed.
// - On deselect, pending bursts finish before idle standby is entered.
// - Low load starts a burst; read-write picks read or write; high load ignores it.
// - Lanes with deasserted select keep their stored contents.
// - Both output clocks held high: read data and echo clocks follow input clocks.
// - A write requested right after a read request becomes a no-operation.
`ifndef SRAM_CORE_CFG_SVH
`define SRAM_CORE_CFG_SVH

`define LANE_W 9
`define CLK_PERIOD_NS 50
`define DLL_LOCK_CYCLES 1024
`define KSTATIC_NS 30
`define KSTATIC_CYC ((((`KSTATIC_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS)) < 1 ? 1 : \
	(((`KSTATIC_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS)))

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DROPPED 8'h08

`define CTRL_DLL_EN_BIT 0
`define CTRL_RESET 32'h0000_0001
`define CLK_PINS_IDLE 4'h7
`define STATUS_LOCKED_BIT 0
`define STATUS_STANDBY_BIT 1
`define STATUS_SINGLE_BIT 2

`endif

// ### core/sram_core_pkg.sv
package sram_core_pkg;
	typedef enum logic [1:0] {
		OUT_IDLE,
		OUT_FIRST,
		OUT_SECOND
	} out_state_t;
endpackage : sram_core_pkg

// ### core/sram_word_array.sv
`timescale 1ns/10ps
`default_nettype none
module sram_word_array #(
	parameter int DATA_W = 18,
	parameter int LANES = 2,
	parameter int WADDR_W = 9
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_we,
	input wire logic [WADDR_W-1:0] i_waddr_a,
	input wire logic [DATA_W-1:0] i_wdata_a,
	input wire logic [LANES-1:0] i_wbyte_n_a,
	input wire logic [WADDR_W-1:0] i_waddr_b,
	input wire logic [DATA_W-1:0] i_wdata_b,
	input wire logic [LANES-1:0] i_wbyte_n_b,
	input wire logic [WADDR_W-1:0] i_raddr_a,
	input wire logic [WADDR_W-1:0] i_raddr_b,
	output logic [DATA_W-1:0] o_rdata_a,
	output logic [DATA_W-1:0] o_rdata_b
);
	localparam int DEPTH = 1 << WADDR_W;
	localparam int LW = DATA_W / LANES;

	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0] mem;
	} array_state_t;

	array_state_t state_reg;
	array_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (i_we) begin
			for (int l = 0; l < LANES; l++) begin
				if (!i_wbyte_n_a[l]) begin
					state_next.mem[i_waddr_a][l*LW +: LW] = i_wdata_a[l*LW +: LW];
				end
				if (!i_wbyte_n_b[l]) begin
					state_next.mem[i_waddr_b][l*LW +: LW] = i_wdata_b[l*LW +: LW];
				end
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_rdata_a = state_reg.mem[i_raddr_a];
	assign o_rdata_b = state_reg.mem[i_raddr_b];
endmodule : sram_word_array
`default_nettype wire

// ### core/ddr_burst2_sram_core.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sram_core_cfg.svh"
module ddr_burst2_sram_core import sram_core_pkg::*; #(
	parameter int DATA_W = 18,
	parameter int ADDR_W = 8,
	parameter logic [7:0] P_KSTATIC_CYCLES = 8'(`KSTATIC_CYC)
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_input_clock,
	input wire logic i_input_clock_n,
	input wire logic i_output_clock,
	input wire logic i_output_clock_n,
	input wire logic i_load_request_n,
	input wire logic i_read_write,
	input wire logic i_burst_start_word_bit,
	input wire logic [ADDR_W-1:0] i_word_address,
	input wire logic [DATA_W-1:0] i_dq,
	input wire logic [DATA_W/`LANE_W-1:0] i_byte_write_select_n,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	output logic o_echo_clock,
	output logic o_echo_clock_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	localparam int LANES = DATA_W / `LANE_W;
	localparam int WA_W = ADDR_W + 1;
	localparam logic [10:0] LOCK_CYC = 11'(`DLL_LOCK_CYCLES);
	localparam logic [31:0] CTRL_RST = `CTRL_RESET;

	typedef struct packed {
		logic [3:0] kc_s1;
		logic [3:0] kc_s2;
		logic [3:0] kc_prev;
		logic [2:0] ctl_s1;
		logic [2:0] ctl_s2;
		logic [ADDR_W-1:0] addr_s1;
		logic [ADDR_W-1:0] addr_s2;
		logic [DATA_W-1:0] dq_s1;
		logic [DATA_W-1:0] dq_s2;
		logic [LANES-1:0] bws_s1;
		logic [LANES-1:0] bws_s2;
		logic [7:0] kstat_cnt;
		logic [10:0] lock_cnt;
		logic locked;
		logic prev_read;
		logic desel;
		logic wr_cap;
		logic wr_pend;
		logic [ADDR_W-1:0] wr_addr;
		logic wr_bsw;
		logic [DATA_W-1:0] wr_da;
		logic [DATA_W-1:0] wr_db;
		logic [LANES-1:0] wr_ba;
		logic [LANES-1:0] wr_bb;
		logic rd_pend;
		logic [DATA_W-1:0] rd_da;
		logic [DATA_W-1:0] rd_db;
		out_state_t out_state;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
		logic echo;
		logic echo_n;
		logic standby;
		logic dll_en;
		logic [15:0] dropped;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} core_state_t;

	core_state_t state_reg;
	core_state_t state_next;

	logic k_rise;
	logic kn_rise;
	logic c_rise;
	logic cn_rise;
	logic single;
	logic out_rise;
	logic out_fall;
	logic ld_n;
	logic rw;
	logic bsw;
	logic [WA_W-1:0] rd_wa_a;
	logic [WA_W-1:0] rd_wa_b;
	logic [WA_W-1:0] wr_wa_a;
	logic [WA_W-1:0] wr_wa_b;
	logic [DATA_W-1:0] arr_a;
	logic [DATA_W-1:0] arr_b;
	logic commit;

	// Per-lane merge of pending write data over array data
	function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] arr,
			input logic [DATA_W-1:0] wd, input logic [LANES-1:0] wb_n, input logic hit);
		logic [DATA_W-1:0] res;
		res = arr;
		for (int l = 0; l < LANES; l++) begin
			if (hit && !wb_n[l]) begin
				res[l*`LANE_W +: `LANE_W] = wd[l*`LANE_W +: `LANE_W];
			end
		end
		return res;
	endfunction : merge_lanes

	assign k_rise = state_reg.kc_s2[3] & ~state_reg.kc_prev[3];
	assign kn_rise = state_reg.kc_s2[2] & ~state_reg.kc_prev[2];
	assign c_rise = state_reg.kc_s2[1] & ~state_reg.kc_prev[1];
	assign cn_rise = state_reg.kc_s2[0] & ~state_reg.kc_prev[0];
	assign single = state_reg.kc_s2[1] & state_reg.kc_s2[0];
	assign out_rise = single ? k_rise : c_rise;
	assign out_fall = single ? kn_rise : cn_rise;
	assign ld_n = state_reg.ctl_s2[2];
	assign rw = state_reg.ctl_s2[1];
	assign bsw = state_reg.ctl_s2[0];
	assign rd_wa_a = {state_reg.addr_s2, bsw};
	assign rd_wa_b = {state_reg.addr_s2, ~bsw};
	assign wr_wa_a = {state_reg.wr_addr, state_reg.wr_bsw};
	assign wr_wa_b = {state_reg.wr_addr, ~state_reg.wr_bsw};
	assign commit = k_rise & state_reg.wr_pend;

	sram_word_array #(
		.DATA_W(DATA_W),
		.LANES(LANES),
		.WADDR_W(WA_W)
	) u_array (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_we(commit),
		.i_waddr_a(wr_wa_a),
		.i_wdata_a(state_reg.wr_da),
		.i_wbyte_n_a(state_reg.wr_ba),
		.i_waddr_b(wr_wa_b),
		.i_wdata_b(state_reg.wr_db),
		.i_wbyte_n_b(state_reg.wr_bb),
		.i_raddr_a(rd_wa_a),
		.i_raddr_b(rd_wa_b),
		.o_rdata_a(arr_a),
		.o_rdata_b(arr_b)
	);

	always_comb begin
		state_next = state_reg;
		// Pin synchronisers
		state_next.kc_s1 = {i_input_clock, i_input_clock_n, i_output_clock, i_output_clock_n};
		state_next.kc_s2 = state_reg.kc_s1;
		state_next.kc_prev = state_reg.kc_s2;
		state_next.ctl_s1 = {i_load_request_n, i_read_write, i_burst_start_word_bit};
		state_next.ctl_s2 = state_reg.ctl_s1;
		state_next.addr_s1 = i_word_address;
		state_next.addr_s2 = state_reg.addr_s1;
		state_next.dq_s1 = i_dq;
		state_next.dq_s2 = state_reg.dq_s1;
		state_next.bws_s1 = i_byte_write_select_n;
		state_next.bws_s2 = state_reg.bws_s1;

		// Output loop lock and static-clock reset
		if (state_reg.kc_s2[3] != state_reg.kc_prev[3]) begin
			state_next.kstat_cnt = '0;
		end else if (state_reg.kstat_cnt != 8'hff) begin
			state_next.kstat_cnt = state_reg.kstat_cnt + 8'h01;
		end
		if (!state_reg.dll_en || state_reg.kstat_cnt >= P_KSTATIC_CYCLES) begin
			state_next.lock_cnt = '0;
			state_next.locked = 1'b0;
		end else if (k_rise && !state_reg.locked) begin
			state_next.lock_cnt = state_reg.lock_cnt + 11'h001;
			state_next.locked = (state_reg.lock_cnt + 11'h001) >= LOCK_CYC;
		end

		// Read output sequencing, before new requests may refill the read slot
		if (out_rise) begin
			if (state_reg.rd_pend) begin
				state_next.dq = state_reg.rd_da;
				state_next.dq_oe = 1'b1;
				state_next.rd_pend = 1'b0;
				state_next.out_state = OUT_FIRST;
			end else begin
				state_next.dq_oe = 1'b0;
				state_next.out_state = OUT_IDLE;
			end
		end else if (out_fall && state_reg.out_state == OUT_FIRST) begin
			state_next.dq = state_reg.rd_db;
			state_next.out_state = OUT_SECOND;
		end
		state_next.echo = single ? state_reg.kc_s2[3] : state_reg.kc_s2[1];
		state_next.echo_n = single ? state_reg.kc_s2[2] : state_reg.kc_s2[0];

		// Write second word on negative input clock
		if (kn_rise && state_reg.wr_cap) begin
			state_next.wr_db = state_reg.dq_s2;
			state_next.wr_bb = state_reg.bws_s2;
			state_next.wr_cap = 1'b0;
			state_next.wr_pend = 1'b1;
		end

		// Requests on positive input clock
		if (k_rise) begin
			if (state_reg.wr_pend) begin
				state_next.wr_pend = 1'b0;
			end
			state_next.desel = ld_n;
			state_next.prev_read = 1'b0;
			if (!ld_n && rw) begin
				state_next.prev_read = 1'b1;
				state_next.rd_pend = 1'b1;
				state_next.rd_da = merge_lanes(arr_a,
					(rd_wa_a == wr_wa_a) ? state_reg.wr_da : state_reg.wr_db,
					(rd_wa_a == wr_wa_a) ? state_reg.wr_ba : state_reg.wr_bb,
					state_reg.wr_pend && (rd_wa_a[WA_W-1:1] == state_reg.wr_addr));
				state_next.rd_db = merge_lanes(arr_b,
					(rd_wa_b == wr_wa_a) ? state_reg.wr_da : state_reg.wr_db,
					(rd_wa_b == wr_wa_a) ? state_reg.wr_ba : state_reg.wr_bb,
					state_reg.wr_pend && (rd_wa_b[WA_W-1:1] == state_reg.wr_addr));
			end else if (!ld_n && !rw) begin
				if (state_reg.prev_read) begin
					state_next.dropped = state_reg.dropped + 16'h0001;
				end else begin
					state_next.wr_cap = 1'b1;
					state_next.wr_addr = state_reg.addr_s2;
					state_next.wr_bsw = bsw;
					state_next.wr_da = state_reg.dq_s2;
					state_next.wr_ba = state_reg.bws_s2;
				end
			end
		end

		// Standby only once every burst has drained
		state_next.standby = state_reg.desel && !state_reg.wr_cap && !state_reg.wr_pend
			&& !state_reg.rd_pend && state_reg.out_state != OUT_FIRST && !state_reg.dq_oe;

		// Register bus
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;
		if (i_psel && i_penable && !state_reg.pready) begin
			state_next.pready = 1'b1;
			unique case (i_paddr)
				`REG_CTRL: state_next.prdata = {31'h0000_0000, state_reg.dll_en};
				`REG_STATUS: state_next.prdata = {29'h0000_0000, single, state_reg.standby, state_reg.locked};
				`REG_DROPPED: state_next.prdata = {16'h0000, state_reg.dropped};
				default: begin
					state_next.prdata = 32'h0000_0000;
					state_next.pslverr = 1'b1;
				end
			endcase
		end
		if (i_psel && i_penable && state_reg.pready && i_pwrite) begin
			if (i_paddr == `REG_CTRL) begin
				state_next.dll_en = i_pwdata[`CTRL_DLL_EN_BIT];
			end else if (i_paddr == `REG_DROPPED) begin
				state_next.dropped = (k_rise && !ld_n && !rw && state_reg.prev_read) ? 16'h0001 : 16'h0000;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_reg <= '0;
			// Clock synchronisers start at idle pin levels, so no false edge follows reset
			state_reg.kc_s1 <= `CLK_PINS_IDLE;
			state_reg.kc_s2 <= `CLK_PINS_IDLE;
			state_reg.kc_prev <= `CLK_PINS_IDLE;
			state_reg.dll_en <= CTRL_RST[`CTRL_DLL_EN_BIT];
			state_reg.out_state <= OUT_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_dq = state_reg.dq;
	assign o_dq_oe = state_reg.dq_oe;
	assign o_echo_clock = state_reg.echo;
	assign o_echo_clock_n = state_reg.echo_n;
	assign o_prdata = state_reg.prdata;
	assign o_pready = state_reg.pready;
	assign o_pslverr = state_reg.pslverr;
endmodule : ddr_burst2_sram_core
`default_nettype wire

// ### dv/sram_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module sram_core_props (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_input_clock,
	input wire logic i_input_clock_n,
	input wire logic i_output_clock,
	input wire logic i_output_clock_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_dq_oe,
	input wire logic o_echo_clock,
	input wire logic o_echo_clock_n
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	wire logic single_mode;
	assign single_mode = i_output_clock && i_output_clock_n;
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_ready_wait: assert property ($rose(i_penable) |-> !o_pready ##1 o_pready)
		else $error("access phase not two cycles");
	a_ready_cause: assert property (o_pready |-> i_psel && i_penable && $past(i_penable))
		else $error("pready outside access phase");
	a_err_unmapped: assert property (o_pready && !(i_paddr inside {8'h00, 8'h04, 8'h08}) |-> o_pslverr && o_prdata == 32'h0)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (o_pready && (i_paddr inside {8'h00, 8'h04, 8'h08}) |-> !o_pslverr)
		else $error("mapped access refused");
	a_err_pulse: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
	a_echo_pos: assert property ((single_mode && i_input_clock) [*5] |-> o_echo_clock)
		else $error("echo clock not following input clock");
	a_echo_neg: assert property ((single_mode && i_input_clock_n) [*5] |-> o_echo_clock_n)
		else $error("negative echo clock not following input clock");
	a_echo_dual: assert property ((!single_mode && i_output_clock) [*5] |-> o_echo_clock)
		else $error("echo clock not following output clock");
	a_reset_quiet: assert property ($rose(i_reset_n) |-> !o_dq_oe && !o_pready)
		else $error("outputs active after reset");
endmodule : sram_core_props
bind ddr_burst2_sram_core sram_core_props sram_core_props_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
	.i_input_clock(i_input_clock), .i_input_clock_n(i_input_clock_n), .i_output_clock(i_output_clock),
	.i_output_clock_n(i_output_clock_n), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_dq_oe(o_dq_oe),
	.o_echo_clock(o_echo_clock), .o_echo_clock_n(o_echo_clock_n));
`default_nettype wire

// ### dv/mem_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_ctrl_model (
	input wire logic i_clock,
	input wire logic [17:0] i_dq,
	output logic o_k,
	output logic o_k_n,
	output logic o_load_request_n,
	output logic o_read_write,
	output logic o_burst_start_word_bit,
	output logic [7:0] o_word_address,
	output logic [17:0] o_dq,
	output logic [1:0] o_byte_write_select_n
);
	logic [17:0] word_a;
	logic [17:0] word_b;
	initial begin
		o_k = 1'b0;
		o_k_n = 1'b1;
		o_load_request_n = 1'b1;
		o_read_write = 1'b1;
		o_burst_start_word_bit = 1'b0;
		o_word_address = 8'h00;
		o_dq = 18'h0;
		o_byte_write_select_n = 2'b11;
	end
	// One input clock period; read words are taken just before the next rises
	task cyc(input logic ld_n, input logic rw, input logic bsel, input logic [7:0] addr, input logic [17:0] da,
		input logic [1:0] sa, input logic [17:0] db, input logic [1:0] sb);
		logic wr;
		wr = !ld_n && !rw;
		o_load_request_n <= ld_n;
		o_read_write <= rw;
		o_burst_start_word_bit <= bsel;
		o_word_address <= addr;
		o_dq <= wr ? da : ~o_dq;
		o_byte_write_select_n <= sa;
		repeat (4) @(posedge i_clock);
		o_k <= 1'b1;
		o_k_n <= 1'b0;
		word_b <= i_dq;
		repeat (4) @(posedge i_clock);
		o_dq <= wr ? db : ~o_dq;
		o_byte_write_select_n <= sb;
		repeat (4) @(posedge i_clock);
		o_k <= 1'b0;
		o_k_n <= 1'b1;
		word_a <= i_dq;
		repeat (4) @(posedge i_clock);
	endtask : cyc
endmodule : mem_ctrl_model
`default_nettype wire

// ### dv/test_ddr_burst2_sram_core.sv
`timescale 1ns/10ps
`default_nettype none
module test_ddr_burst2_sram_core;
	logic clock, reset_n, psel, penable, pwrite, pready, pslverr, e, oe;
	logic k, k_n, ld_n, rw, bsel;
	logic [7:0] paddr, addr;
	logic [31:0] pwdata, prdata, v;
	logic [17:0] ctl_dq, dut_dq, dq_pin;
	logic [1:0] bws_n;
	logic dual, c_pin, c_n_pin;
	int n_fail;
	int compares;
	assign dq_pin = oe ? dut_dq : ctl_dq;
	// Output clocks tied high, or following the input clocks in dual clock mode
	assign c_pin = dual ? k : 1'b1;
	assign c_n_pin = dual ? k_n : 1'b1;
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	ddr_burst2_sram_core #(.DATA_W(18), .ADDR_W(8), .P_KSTATIC_CYCLES(8'h28)) ddr_burst2_sram_core_i (
		.i_clock(clock), .i_reset_n(reset_n), .i_input_clock(k), .i_input_clock_n(k_n), .i_output_clock(c_pin),
		.i_output_clock_n(c_n_pin), .i_load_request_n(ld_n), .i_read_write(rw), .i_burst_start_word_bit(bsel),
		.i_word_address(addr), .i_dq(dq_pin), .i_byte_write_select_n(bws_n), .o_dq(dut_dq), .o_dq_oe(oe),
		.o_echo_clock(), .o_echo_clock_n(), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
	mem_ctrl_model mem_ctrl_model_i (.i_clock(clock), .i_dq(dq_pin), .o_k(k), .o_k_n(k_n), .o_load_request_n(ld_n),
		.o_read_write(rw), .o_burst_start_word_bit(bsel), .o_word_address(addr), .o_dq(ctl_dq),
		.o_byte_write_select_n(bws_n));
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [31:0] exp_v, input logic [31:0] got);
		compares++;
		if (got !== exp_v) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp_v, got);
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			print_verdict();
		end
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	// Load held high with write-looking inputs at word 7
	task no_operation;
		mem_ctrl_model_i.cyc(1'b1, 1'b0, 1'b0, 8'h07, 18'h3ffff, 2'b00, 18'h3ffff, 2'b00);
	endtask : no_operation
	task rd_burst(input logic [7:0] a, input logic b, input logic [17:0] ea, input logic [17:0] eb);
		mem_ctrl_model_i.cyc(1'b0, 1'b1, b, a, 18'h0, 2'b11, 18'h0, 2'b11);
		no_operation();
		chk("read word a", {14'h0, ea}, {14'h0, mem_ctrl_model_i.word_a});
		no_operation();
		chk("read word b", {14'h0, eb}, {14'h0, mem_ctrl_model_i.word_b});
	endtask : rd_burst
	task t_regs;
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h1, v);
		apb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h4, v & 32'h5);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, v);
		$display("test regs done");
	endtask : t_regs
	task t_data;
		mem_ctrl_model_i.cyc(1'b0, 1'b0, 1'b0, 8'h05, 18'h12345, 2'b00, 18'h0abcd, 2'b00);
		rd_burst(8'h05, 1'b1, 18'h0abcd, 18'h12345);
		mem_ctrl_model_i.cyc(1'b0, 1'b0, 1'b0, 8'h05, 18'h3ffff, 2'b10, 18'h0, 2'b01);
		no_operation();
		rd_burst(8'h05, 1'b0, 18'h123ff, 18'h001cd);
		$display("test data done");
	endtask : t_data
	task t_drop;
		apb(1'b1, 8'h08, 32'h0);
		mem_ctrl_model_i.cyc(1'b0, 1'b1, 1'b0, 8'h07, 18'h0, 2'b11, 18'h0, 2'b11);
		mem_ctrl_model_i.cyc(1'b0, 1'b0, 1'b0, 8'h07, 18'h155aa, 2'b00, 18'h2aa55, 2'b00);
		apb(1'b0, 8'h08, 32'h0);
		chk("dropped count", 32'h1, v & 32'hffff);
		rd_burst(8'h07, 1'b0, 18'h0, 18'h0);
		$display("test drop done");
	endtask : t_drop
	task t_lock;
		// About 1014 input clock rises so far: still short of lock
		repeat (1000) no_operation();
		apb(1'b0, 8'h04, 32'h0);
		chk("status not locked", 32'h0, v & 32'h1);
		repeat (30) no_operation();
		apb(1'b0, 8'h04, 32'h0);
		chk("status idle", 32'h7, v & 32'h7);
		chk("dq released", 32'h0, {31'h0, oe});
		repeat (60) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0);
		chk("status stopped", 32'h0, v & 32'h1);
		$display("test lock done");
	endtask : t_lock
	// Output clocks running: read data and echo clocks follow them
	task t_cclk;
		dual <= 1'b1;
		no_operation();
		apb(1'b0, 8'h04, 32'h0);
		chk("status dual clock", 32'h0, v & 32'h4);
		rd_burst(8'h05, 1'b1, 18'h001cd, 18'h123ff);
		$display("test output clocks done");
	endtask : t_cclk
	initial begin
		n_fail = 0;
		compares = 0;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dual = 1'b0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_regs();
		t_data();
		t_drop();
		t_lock();
		t_cclk();
		print_verdict();
	end
endmodule : test_ddr_burst2_sram_core
`default_nettype wire
